//--- hdl/lepi_core.sv
/*
 * Linear encoder process image: scales position and speed by the step
 * settings and streams the four image words through a FIFO to the island
 * gateway, either on the gateway's update request or on the cyclic timer.
 * Assumes measured values and requests come from logic on clk_i.
 */
// Functional notes
// - Position step limited to 5000 .. 2147483647.
// - Default step: one count per 5 um.
// - Speed step limited to 10 .. 2147483647.
// - Default speed step 10, count per 0.1 mm/s.
// - Timer off: send on gateway update requests.
// - Timer on: send every selected period.
// - Image is four contiguous 16-bit words.
// - Position 32-bit, low word first.
// - Speed is one 16-bit word.
// - Reserved field carried, meaningless.
`timescale 1ns/10ps
`include "lepi_map.svh"

// ************************************************************
// FIFO with a registered output stage.
// ************************************************************
module lepi_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Filling side.
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // Draining side.
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   // All state of the FIFO.
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem; // Storage.
      logic [AW-1:0] wptr;              // Write pointer.
      logic [AW-1:0] rptr;              // Read pointer.
      logic [AW:0] cnt;                 // Words held in storage.
      logic ovalid;                     // Output stage holds a word.
      logic [WIDTH-1:0] odata;          // Output stage word.
   } lepi_fifo_st_t;
   lepi_fifo_st_t st_ff;
   lepi_fifo_st_t nxt_st;
   logic push;
   logic pop;

   // Full storage refuses the source, so back-pressure reaches it.
   assign in_ready_o = (st_ff.cnt != (AW+1)'(DEPTH));
   assign out_valid_o = st_ff.ovalid;
   assign out_data_o = st_ff.odata;

   // Next state: write at the tail, refill the output stage from the head.
   always_comb begin
      nxt_st = st_ff;
      push = in_valid_i && in_ready_o;
      pop = (st_ff.cnt != '0) && (!st_ff.ovalid || out_ready_i);
      if (push) begin
         nxt_st.mem[st_ff.wptr] = in_data_i;
         nxt_st.wptr = st_ff.wptr + 1'b1;
      end
      if (pop) begin
         nxt_st.odata = st_ff.mem[st_ff.rptr];
         nxt_st.rptr = st_ff.rptr + 1'b1;
         nxt_st.ovalid = 1'b1;
      end else if (out_ready_i) begin
         nxt_st.ovalid = 1'b0;
      end
      nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   // State register.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule : lepi_fifo

// ************************************************************
// Scaling, triggering and image assembly.
// ************************************************************
module lepi_core #(
   parameter int MS_CYC = `LEPI_MS_CYC
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Measured magnet state, in 0.001 um and 0.01 mm/s units.
   input wire logic signed [47:0] meas_pos_i,
   input wire logic signed [31:0] meas_spd_i,
   // Configuration.
   input wire logic [31:0] pos_step_i,
   input wire logic [31:0] spd_step_i,
   input wire lepi_pkg::lepi_cyc_t cyc_sel_i,
   // Update request from the island gateway, one-cycle pulse.
   input wire logic island_gateway_req_i,
   // Image words toward the island gateway.
   output logic image_valid_o,
   input wire logic image_ready_i,
   output lepi_pkg::lepi_word_t image_word_o,
   // Activity.
   output logic busy_o
);
   typedef enum logic [1:0] {
      ST_IDLE, ST_DIV_POS, ST_DIV_SPD, ST_PUSH
   } lepi_fsm_t;
   // All state of the core.
   typedef struct packed {
      lepi_fsm_t fsm;            // Sequencer state.
      logic pend;                // Send requested, not yet started.
      logic [14:0] ms_cnt;       // Cycles inside the current millisecond.
      logic [9:0] per_cnt;       // Milliseconds inside the current period.
      logic [47:0] dvd;          // Dividend shifting out, quotient in.
      logic [32:0] rem;          // Partial remainder.
      logic [5:0] bit_cnt;       // Division steps left.
      logic neg;                 // Quotient sign.
      logic signed [31:0] spd_m; // Speed captured with the position.
      logic [31:0] pos_q;        // Position count.
      logic [15:0] spd_q;        // Speed count.
      logic [1:0] widx;          // Next image word to push.
      logic busy;                // Registered busy output.
   } lepi_st_t;

   lepi_st_t st_ff;
   lepi_st_t nxt_st;
   lepi_pkg::lepi_word_t push_word;
   logic push_valid;
   logic push_ready;
   logic [31:0] pos_div;
   logic [31:0] spd_div;
   logic [9:0] period;
   logic [47:0] q_mag;
   logic [47:0] q_sgn;
   logic [32:0] trial;
   logic ms_tick;

   // Settings are held inside their documented range.
   always_comb begin
      pos_div = pos_step_i;
      if (pos_step_i < `LEPI_POS_STEP_MIN) begin
         pos_div = `LEPI_POS_STEP_MIN;
      end else if (pos_step_i > `LEPI_POS_STEP_MAX) begin
         pos_div = `LEPI_POS_STEP_MAX;
      end
      spd_div = spd_step_i;
      if (spd_step_i < `LEPI_SPD_STEP_MIN) begin
         spd_div = `LEPI_SPD_STEP_MIN;
      end else if (spd_step_i > `LEPI_SPD_STEP_MAX) begin
         spd_div = `LEPI_SPD_STEP_MAX;
      end
   end

   // Period of the cyclic timer in milliseconds.
   always_comb begin
      case (cyc_sel_i)
         lepi_pkg::CYC_20MS: period = `LEPI_PER_20MS;
         lepi_pkg::CYC_50MS: period = `LEPI_PER_50MS;
         lepi_pkg::CYC_100MS: period = `LEPI_PER_100MS;
         lepi_pkg::CYC_250MS: period = `LEPI_PER_250MS;
         lepi_pkg::CYC_500MS: period = `LEPI_PER_500MS;
         lepi_pkg::CYC_1S: period = `LEPI_PER_1S;
         default: period = '0;
      endcase
   end

   // Image word for the current index; the reserved word is all zero.
   always_comb begin
      push_word.idx = st_ff.widx;
      case (st_ff.widx)
         `LEPI_IDX_POS_LO: push_word.data = st_ff.pos_q[15:0];
         `LEPI_IDX_POS_HI: push_word.data = st_ff.pos_q[31:16];
         `LEPI_IDX_SPEED: push_word.data = st_ff.spd_q;
         default: push_word.data = `LEPI_RSVD_VALUE;
      endcase
      push_valid = (st_ff.fsm == ST_PUSH);
   end

   // Next state: timer, request latch, shared divider and word push.
   always_comb begin
      nxt_st = st_ff;
      q_mag = '0;
      q_sgn = '0;
      trial = '0;
      ms_tick = (st_ff.ms_cnt == 15'(MS_CYC - 1));
      // Starting a send consumes the flag; a set in this same cycle wins.
      if (st_ff.fsm == ST_IDLE) begin
         nxt_st.pend = 1'b0;
      end
      // Millisecond prescaler and period counter; idle when timer is off.
      if (cyc_sel_i == lepi_pkg::CYC_OFF) begin
         nxt_st.ms_cnt = '0;
         nxt_st.per_cnt = '0;
      end else if (ms_tick) begin
         nxt_st.ms_cnt = '0;
         if (st_ff.per_cnt >= period - 10'd1) begin
            nxt_st.per_cnt = '0;
            nxt_st.pend = 1'b1;
         end else begin
            nxt_st.per_cnt = st_ff.per_cnt + 10'd1;
         end
      end else begin
         nxt_st.ms_cnt = st_ff.ms_cnt + 15'd1;
      end
      // Gateway requests only drive sending while the timer is off.
      if (cyc_sel_i == lepi_pkg::CYC_OFF && island_gateway_req_i) begin
         nxt_st.pend = 1'b1;
      end
      case (st_ff.fsm)
         ST_IDLE: begin
            if (st_ff.pend) begin
               // Capture both quantities at one instant.
               nxt_st.neg = meas_pos_i[47];
               nxt_st.dvd = meas_pos_i[47] ? -meas_pos_i : meas_pos_i;
               nxt_st.spd_m = meas_spd_i;
               nxt_st.rem = '0;
               nxt_st.bit_cnt = 6'd48;
               nxt_st.fsm = ST_DIV_POS;
            end
         end
         ST_DIV_POS, ST_DIV_SPD: begin
            // One restoring step per cycle on magnitudes.
            trial = {st_ff.rem[31:0], st_ff.dvd[47]};
            nxt_st.dvd = {st_ff.dvd[46:0], 1'b0};
            if (trial >= {1'b0, (st_ff.fsm == ST_DIV_POS) ? pos_div
                  : spd_div}) begin
               nxt_st.rem = trial - {1'b0, (st_ff.fsm == ST_DIV_POS)
                  ? pos_div : spd_div};
               nxt_st.dvd[0] = 1'b1;
            end else begin
               nxt_st.rem = trial;
            end
            nxt_st.bit_cnt = st_ff.bit_cnt - 6'd1;
            if (st_ff.bit_cnt == 6'd1) begin
               // Sign applied to the magnitude truncates toward zero.
               q_mag = nxt_st.dvd;
               q_sgn = st_ff.neg ? 48'(-q_mag) : q_mag;
               if (st_ff.fsm == ST_DIV_POS) begin
                  nxt_st.pos_q = q_sgn[31:0];
                  nxt_st.neg = st_ff.spd_m[31];
                  nxt_st.dvd = 48'($unsigned(st_ff.spd_m[31]
                     ? -st_ff.spd_m : st_ff.spd_m));
                  nxt_st.rem = '0;
                  nxt_st.bit_cnt = 6'd48;
                  nxt_st.fsm = ST_DIV_SPD;
               end else begin
                  // Quotient is below 2^31, so 16-bit saturation suffices.
                  if (q_mag > 48'h0000_0000_7FFF) begin
                     nxt_st.spd_q = st_ff.neg ? 16'h8001 : 16'h7FFF;
                  end else begin
                     nxt_st.spd_q = q_sgn[15:0];
                  end
                  nxt_st.widx = `LEPI_IDX_POS_LO;
                  nxt_st.fsm = ST_PUSH;
               end
            end
         end
         ST_PUSH: begin
            // Each word waits for room, so a stalled gateway stalls us.
            if (push_ready) begin
               nxt_st.widx = st_ff.widx + 2'd1;
               if (st_ff.widx == `LEPI_IDX_RSVD) begin
                  nxt_st.fsm = ST_IDLE;
               end
            end
         end
         default: nxt_st.fsm = ST_IDLE;
      endcase
      nxt_st.busy = (nxt_st.fsm != ST_IDLE);
   end

   // State register.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign busy_o = st_ff.busy;
   // The FIFO output stage is a register, so image outputs come from flops.
   lepi_fifo #(.WIDTH($bits(lepi_pkg::lepi_word_t)), .DEPTH(16)) u_fifo (
      .clk_i(clk_i), .rst_i(rst_i),
      .in_valid_i(push_valid), .in_ready_o(push_ready),
      .in_data_i(push_word),
      .out_valid_o(image_valid_o), .out_ready_i(image_ready_i),
      .out_data_o(image_word_o));
endmodule : lepi_core

//--- hdl/lepi_map.svh
/*
 * Constants of the linear encoder process image: step limits and defaults,
 * word order of the image and timing counts of the cyclic timer.
 * Assumes inclusion by bare name from design and bench files.
 */
`ifndef LEPI_MAP_SVH
`define LEPI_MAP_SVH

// ************************************************************
// Step settings.
// ************************************************************
`define LEPI_POS_STEP_MIN 32'h0000_1388
`define LEPI_POS_STEP_MAX 32'h7FFF_FFFF
`define LEPI_POS_STEP_RST 32'h0000_1388
`define LEPI_SPD_STEP_MIN 32'h0000_000A
`define LEPI_SPD_STEP_MAX 32'h7FFF_FFFF
`define LEPI_SPD_STEP_RST 32'h0000_000A

// ************************************************************
// Word positions inside the four-word image.
// ************************************************************
`define LEPI_IDX_POS_LO 2'h0
`define LEPI_IDX_POS_HI 2'h1
`define LEPI_IDX_SPEED 2'h2
`define LEPI_IDX_RSVD 2'h3
`define LEPI_RSVD_VALUE 16'h0000

// ************************************************************
// Timing: clock rate, one millisecond, and the timer periods in ms.
// ************************************************************
`define LEPI_CLK_HZ 20000000
`define LEPI_MS_PER_S 1000
`define LEPI_MS_CYC (`LEPI_CLK_HZ / `LEPI_MS_PER_S)
`define LEPI_PER_20MS 10'd20
`define LEPI_PER_50MS 10'd50
`define LEPI_PER_100MS 10'd100
`define LEPI_PER_250MS 10'd250
`define LEPI_PER_500MS 10'd500
`define LEPI_PER_1S 10'd1000

`endif

//--- hdl/lepi_pkg.sv
/*
 * Types of the linear encoder process image block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package lepi_pkg;

   // Selection of the cyclic transmit timer.
   typedef enum logic [2:0] {
      CYC_OFF, CYC_20MS, CYC_50MS, CYC_100MS, CYC_250MS, CYC_500MS, CYC_1S
   } lepi_cyc_t;

   // One word of the image with its place in the image.
   typedef struct packed {
      logic [1:0] idx;
      logic [15:0] data;
   } lepi_word_t;

endpackage : lepi_pkg

//--- tb/lepi_core_asserts.sv
/* Port checker for lepi_core, bound to every instance below.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/10ps
module lepi_core_asserts #(
   parameter int MS_CYC = 20000
) (
   // Clock, reset and inputs.
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic signed [47:0] meas_pos_i,
   input wire logic signed [31:0] meas_spd_i,
   input wire logic [31:0] pos_step_i,
   input wire logic [31:0] spd_step_i,
   input wire lepi_pkg::lepi_cyc_t cyc_sel_i,
   input wire logic island_gateway_req_i,
   input wire logic image_ready_i,
   // Outputs watched.
   input wire logic image_valid_o,
   input wire lepi_pkg::lepi_word_t image_word_o,
   input wire logic busy_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // Last index taken; reset to 3 so that word 0 must come first.
   logic [1:0] last_ff;
   logic take;
   assign take = image_valid_o && image_ready_i;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_ff <= 2'h3;
      end else if (take) begin
         last_ff <= image_word_o.idx;
      end
   end
   AST_QUIET: assert property (
      $fell(rst_i) |-> !image_valid_o && !busy_o && image_word_o == 18'h0_0000)
      else $error("outputs active after reset");
   AST_HOLD: assert property (
      image_valid_o && !image_ready_i
      |=> image_valid_o && $stable(image_word_o))
      else $error("word changed before it was taken");
   AST_ORDER: assert property (
      take |-> image_word_o.idx == last_ff + 2'h1)
      else $error("image words out of order");
   AST_RSVD: assert property (
      image_valid_o && image_word_o.idx == 2'h3
      |-> image_word_o.data == 16'h0000)
      else $error("reserved word not zero");
   AST_REQ_BUSY: assert property (
      island_gateway_req_i && !busy_o && cyc_sel_i == lepi_pkg::CYC_OFF
      |-> ##2 busy_o) else $error("request did not start a send");
   AST_DROP: assert property (
      $fell(image_valid_o) && !$past(rst_i) |-> $past(image_ready_i))
      else $error("valid dropped without a take");
   AST_DIVIDE: assert property (
      $rose(busy_o) |-> busy_o [*8])
      else $error("busy too short for the divisions");
   AST_FIRST: assert property (
      $rose(busy_o) && !image_valid_o |-> !image_valid_o [*8])
      else $error("word offered before division ended");
   COV_STALL: cover property (busy_o && image_valid_o && !image_ready_i);
   COV_TIMER: cover property ($rose(busy_o) && cyc_sel_i != lepi_pkg::CYC_OFF);
   COV_RSVD: cover property (take && image_word_o.idx == 2'h3);
endmodule : lepi_core_asserts
bind lepi_core lepi_core_asserts #(.MS_CYC(MS_CYC)) u_chk (
   .clk_i(clk_i), .rst_i(rst_i), .meas_pos_i(meas_pos_i),
   .meas_spd_i(meas_spd_i), .pos_step_i(pos_step_i),
   .spd_step_i(spd_step_i), .cyc_sel_i(cyc_sel_i),
   .island_gateway_req_i(island_gateway_req_i),
   .image_ready_i(image_ready_i), .image_valid_o(image_valid_o),
   .image_word_o(image_word_o), .busy_o(busy_o));

//--- tb/lepi_gw_model.sv
/* Gateway model: takes image words at full rate or one in 64 cycles
   and assembles position and speed. Assumes lepi_pkg is compiled. */
`timescale 1ns/10ps
module lepi_gw_model (
   // Clock, reset and pace.
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic slow_i,
   // Image words.
   input wire logic image_valid_i,
   input wire lepi_pkg::lepi_word_t image_word_i,
   output logic image_ready_o,
   // Assembled frame and frame count.
   output logic [31:0] pos_o,
   output logic [15:0] spd_o,
   output logic [7:0] frames_o
);
   logic [5:0] pace_ff;
   // Ready moves just after an edge; slow mode stalls 63 of 64 cycles.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pace_ff <= 6'h00;
         image_ready_o <= 1'b0;
         frames_o <= 8'h00;
      end else begin
         pace_ff <= pace_ff + 6'h01;
         image_ready_o <= !slow_i || pace_ff == 6'h3E;
         if (image_valid_i && image_ready_o) begin
            case (image_word_i.idx)
               2'h0: pos_o[15:0] <= image_word_i.data;
               2'h1: pos_o[31:16] <= image_word_i.data;
               2'h2: spd_o <= image_word_i.data;
               default: frames_o <= frames_o + 8'h01;
            endcase
         end
      end
   end
endmodule : lepi_gw_model

//--- tb/tb.sv
/* Bench: drives measurements and settings, reads frames via the
   gateway model. Assumes the design, checker and model files. */
`timescale 1ns/10ps
module tb;
   logic clk_i, rst_i, req, slow, busy, vld, rdy;
   logic signed [47:0] mpos;
   logic signed [31:0] mspd;
   logic [31:0] pstep, sstep, gpos;
   logic [15:0] gspd;
   logic [7:0] frames, f0;
   lepi_pkg::lepi_cyc_t cyc;
   lepi_pkg::lepi_word_t word;
   int mismatches = 0, checked = 0, cycles = 0, t0;
   int per[6] = '{20, 50, 100, 250, 500, 1000};
   lepi_core #(.MS_CYC(10)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
      .meas_pos_i(mpos), .meas_spd_i(mspd), .pos_step_i(pstep),
      .spd_step_i(sstep), .cyc_sel_i(cyc), .island_gateway_req_i(req),
      .image_valid_o(vld), .image_ready_i(rdy), .image_word_o(word),
      .busy_o(busy));
   lepi_gw_model u_gw (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
      .image_valid_i(vld), .image_word_i(word), .image_ready_o(rdy),
      .pos_o(gpos), .spd_o(gspd), .frames_o(frames));
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   always @(posedge clk_i) cycles <= cycles + 1;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time,
            seen, exp);
      end
   endtask : check
   task automatic end_of_test();
      $display("Compared %0d, mismatched %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test
   // Waits, bounded, for one more frame at the gateway.
   task automatic wait_frame();
      int n;
      n = 0;
      f0 = frames;
      while (frames === f0 && n < 20000) begin
         @(negedge clk_i);
         n++;
      end
      check({24'h0, frames}, {24'h0, f0 + 8'h01});
   endtask : wait_frame
   // One request pulse, then the frame read back and compared.
   task automatic frame(input logic signed [47:0] p,
      input logic signed [31:0] s, input logic [31:0] ep,
      input logic [15:0] es);
      mpos = p;
      mspd = s;
      req = 1'b1;
      @(negedge clk_i);
      req = 1'b0;
      wait_frame();
      check(gpos, ep);
      check({16'h0, gspd}, {16'h0, es});
   endtask : frame
   initial begin
      {rst_i, req, slow, mpos, mspd} = {1'b1, 1'b0, 1'b0, 48'h0, 32'h0};
      cyc = lepi_pkg::CYC_OFF;
      pstep = 32'h0000_1388;
      sstep = 32'h0000_000A;
      repeat (16) @(negedge clk_i);
      rst_i = 1'b0;
      frame(48'sh0000_00BC_614E, 32'sh0000_3039,
         32'h0000_09A5, 16'h04D2);
      frame(-48'sh0000_00BC_614E, -32'sh0000_3039,
         32'hFFFF_F65B, 16'hFB2E);
      $display("Test default steps done");
      // A step below the floor must divide by 5000, not 4999.
      pstep = 32'h0000_1387;
      frame(48'sh0000_0000_270E, 32'sh0000_0000,
         32'h0000_0001, 16'h0000);
      pstep = 32'h0000_2710;
      sstep = 32'h0000_03E8;
      frame(48'sh0000_0001_387F, 32'sh0000_2710,
         32'h0000_0007, 16'h000A);
      // Steps above the ceiling and below the speed floor are clamped.
      pstep = 32'hFFFF_FFFF;
      sstep = 32'h0000_0009;
      frame(48'sh0000_FFFF_FFFE, 32'sh0000_005A,
         32'h0000_0002, 16'h0009);
      $display("Test step limits done");
      f0 = frames;
      repeat (500) @(negedge clk_i);
      check({24'h0, frames}, {24'h0, f0});
      for (int i = 0; i < 6; i++) begin
         cyc = lepi_pkg::lepi_cyc_t'(3'(i + 1));
         wait_frame();
         t0 = cycles;
         wait_frame();
         check(cycles - t0, per[i] * 10);
         cyc = lepi_pkg::CYC_OFF;
         @(negedge clk_i);
      end
      $display("Test cyclic timer done");
      pstep = 32'h0000_2710;
      slow = 1'b1;
      mpos = 48'sh0000_0001_3880;
      repeat (20) begin
         req = 1'b1;
         @(negedge clk_i);
         req = 1'b0;
         repeat (39) @(negedge clk_i);
      end
      for (int n = 0; n < 8000 && (busy !== 1'b0 || vld !== 1'b0); n++)
         @(negedge clk_i);
      check({31'h0, busy | vld}, 32'h0);
      check(gpos, 32'h0000_0008);
      $display("Test full buffer done");
      end_of_test();
   end
   initial begin
      #3000000;
      mismatches++;
      end_of_test();
   end
endmodule : tb
